// ---- amis_top.sv ----
// Overview of operation
// - Port-1 three-bit selector, read/write, resets zero
// - Port-2 identical selector, same encoding, resets zero
// - Code zero drives constant low mute
// - Codes 1-3 route shared data/serial pins
// - Code 4 high clock, 5 slave-in
// - Code 6 chip select, 7 enable pin
// - Upper bits not stored; read zero
// - Reduced variant: port-2 register reserved, inert
`timescale 1ns/1ns
module amis_top #(
  parameter bit HAS_PORT2 = 1'b1
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire amis_pkg::amis_av_req_t av_req,
  output amis_pkg::amis_av_rsp_t      av_rsp,
  input  wire amis_pkg::amis_pins_t   pins,
  output logic                        port1_mute_in,
  output logic                        port2_mute_in
);
  import amis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [SEL_W-1:0] merge_sel(
    input logic [SEL_W-1:0]  cur,
    input logic [DATA_W-1:0] wdata,
    input logic [BE_W-1:0]   be
  );
    merge_sel = be[SEL_BYTE] ? wdata[SEL_LSB +: SEL_W] : cur;
  endfunction : merge_sel

  function automatic logic [DATA_W-1:0] read_word(
    input logic [SEL_W-1:0] sel
  );
    read_word = {{(DATA_W-SEL_W){1'b0}}, sel};
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic              ack_q;
  logic              ack_d;
  logic [SEL_W-1:0]  port1_mute_source_sel_q;
  logic [SEL_W-1:0]  port1_mute_source_sel_d;
  logic [SEL_W-1:0]  port2_mute_source_sel_q;
  logic [SEL_W-1:0]  port2_mute_source_sel_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0]        resp_q;
  logic [1:0]        resp_d;

  wire req        = av_req.read | av_req.write;
  wire hit_p1     = (av_req.address == PORT1_CFG_ADDR);
  wire hit_p2     = (av_req.address == PORT2_CFG_ADDR);
  wire mapped     = hit_p1 | hit_p2;
  wire wr_commit  = av_req.write & ack_q;
  wire rd_capture = av_req.read & ~ack_q;
  wire p2_live    = HAS_PORT2;

  // One wait cycle, then the answer
  assign ack_d = req & ~ack_q;

  assign port1_mute_source_sel_d = (wr_commit & hit_p1) ?
    merge_sel(port1_mute_source_sel_q, av_req.writedata, av_req.byteenable) :
    port1_mute_source_sel_q;

  assign port2_mute_source_sel_d = (wr_commit & hit_p2 & p2_live) ?
    merge_sel(port2_mute_source_sel_q, av_req.writedata, av_req.byteenable) :
    port2_mute_source_sel_q;

  // Reserved bits read zero; absent port-2 reads zero
  assign rdata_d = !rd_capture ? rdata_q :
                   hit_p1      ? read_word(port1_mute_source_sel_q) :
                   (hit_p2 & p2_live) ? read_word(port2_mute_source_sel_q) :
                   '0;

  assign resp_d = !(req & ~ack_q) ? resp_q :
                  mapped          ? RESP_OKAY :
                  RESP_SLVERR;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q                   <= 1'b0;
      port1_mute_source_sel_q <= SEL_RESET;
      port2_mute_source_sel_q <= SEL_RESET;
      rdata_q                 <= '0;
      resp_q                  <= RESP_OKAY;
    end else begin
      ack_q                   <= ack_d;
      port1_mute_source_sel_q <= port1_mute_source_sel_d;
      port2_mute_source_sel_q <= port2_mute_source_sel_d;
      rdata_q                 <= rdata_d;
      resp_q                  <= resp_d;
    end
  end

  assign av_rsp.readdata    = rdata_q;
  assign av_rsp.waitrequest = req & ~ack_q;
  assign av_rsp.response    = resp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mute source selection

  logic port2_mux_out;

  amis_mute_mux u_port1_mux (
    .sel  (port1_mute_source_sel_q),
    .pins (pins),
    .mute (port1_mute_in)
  );

  amis_mute_mux u_port2_mux (
    .sel  (port2_mute_source_sel_q),
    .pins (pins),
    .mute (port2_mux_out)
  );

  assign port2_mute_in = p2_live & port2_mux_out;

endmodule : amis_top

// ---- amis_pkg.sv ----
package amis_pkg;

  localparam int unsigned ADDR_W          = 32;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned BE_W            = DATA_W / 8;
  localparam int unsigned SEL_W           = 3;

  localparam logic [ADDR_W-1:0] PORT1_CFG_ADDR = 32'h4000001c;
  localparam logic [ADDR_W-1:0] PORT2_CFG_ADDR = 32'h40000020;

  localparam logic [SEL_W-1:0]  SEL_RESET      = 3'h0;
  localparam int unsigned       SEL_LSB        = 0;
  localparam int unsigned       SEL_BYTE       = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Selector codes
  typedef enum logic [SEL_W-1:0] {
    SRC_ZERO      = 3'h0,
    SRC_P0D7      = 3'h1,
    SRC_P0D8      = 3'h2,
    SRC_P0D9      = 3'h3,
    SRC_P2_HCLK   = 3'h4,
    SRC_SP1_SIN   = 3'h5,
    SRC_SP1_CS    = 3'h6,
    SRC_SP1_EN    = 3'h7
  } amis_src_t;

  // Shared pin levels that may drive a mute input
  typedef struct packed {
    logic port0_data7_second_serial_periph_clock_pin;
    logic port0_data8_port1_data5_second_serial_periph_slave_out_pin;
    logic port0_data9_port1_data4_second_serial_periph_slave_in_pin;
    logic port2_rx_high_clock_pin;
    logic first_serial_periph_slave_in_pin;
    logic first_serial_periph_chip_select_pin;
    logic first_serial_periph_enable_pin;
  } amis_pins_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } amis_av_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic [1:0]        response;
  } amis_av_rsp_t;

endpackage : amis_pkg

// ---- amis_mute_mux.sv ----
`timescale 1ns/1ns
module amis_mute_mux (
  input  wire logic [amis_pkg::SEL_W-1:0] sel,
  input  wire amis_pkg::amis_pins_t       pins,
  output logic                            mute
);
  import amis_pkg::*;

  // Purely combinational, no frame alignment
  always_comb begin
    case (amis_src_t'(sel))
      SRC_ZERO:    mute = 1'b0;
      SRC_P0D7:    mute = pins.port0_data7_second_serial_periph_clock_pin;
      SRC_P0D8:    mute = pins.port0_data8_port1_data5_second_serial_periph_slave_out_pin;
      SRC_P0D9:    mute = pins.port0_data9_port1_data4_second_serial_periph_slave_in_pin;
      SRC_P2_HCLK: mute = pins.port2_rx_high_clock_pin;
      SRC_SP1_SIN: mute = pins.first_serial_periph_slave_in_pin;
      SRC_SP1_CS:  mute = pins.first_serial_periph_chip_select_pin;
      SRC_SP1_EN:  mute = pins.first_serial_periph_enable_pin;
      default:     mute = 1'b0;
    endcase
  end

endmodule : amis_mute_mux

// ---- amis_top_chk.sv ----
`timescale 1ns/1ns
module amis_chk #(parameter bit HAS_PORT2 = 1'b1) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire amis_pkg::amis_av_req_t av_req,
  input wire amis_pkg::amis_av_rsp_t av_rsp,
  input wire amis_pkg::amis_pins_t   pins,
  input wire logic                   port1_mute_in,
  input wire logic                   port2_mute_in
);
  import amis_pkg::*;
  logic [2:0] s1_q, s2_q;
  wire  [6:0] pv = pins;
  wire        wr = av_req.write & ~av_rsp.waitrequest & av_req.byteenable[0];
  wire        rd = av_req.read & ~av_rsp.waitrequest;
  wire        a1 = av_req.address == PORT1_CFG_ADDR;
  wire        a2 = av_req.address == PORT2_CFG_ADDR;
  wire        m1 = (s1_q == 3'h0) ? 1'b0 : pv[3'h7 - s1_q];
  wire        m2 = (s2_q == 3'h0) ? 1'b0 : pv[3'h7 - s2_q];
  // Shadow selectors
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      if (wr && a1) s1_q <= av_req.writedata[2:0];
      if (wr && a2 && HAS_PORT2) s2_q <= av_req.writedata[2:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  one_wait_a:
    assert property ((av_req.read | av_req.write) && av_rsp.waitrequest |=> !av_rsp.waitrequest)
    else $error("wait not one cycle");
  idle_ready_a:
    assert property (!(av_req.read | av_req.write) |-> !av_rsp.waitrequest) else $error("idle wait");
  port1_mux_a:
    assert property (port1_mute_in == m1) else $error("port1 mute");
  port2_mux_a:
    assert property (port2_mute_in == m2) else $error("port2 mute");
  zero_code_a:
    assert property (s1_q == 3'h0 |-> !port1_mute_in) else $error("code zero");
  port1_read_a:
    assert property (rd && a1 |-> av_rsp.readdata == {29'h0, s1_q}) else $error("port1 read");
  port2_read_a:
    assert property (rd && a2 |-> av_rsp.readdata == {29'h0, s2_q}) else $error("port2 read");
  upper_zero_a:
    assert property (rd |-> av_rsp.readdata[31:3] == 29'h0) else $error("upper bits");
  unmapped_err_a:
    assert property (rd && !a1 && !a2 |-> av_rsp.response == RESP_SLVERR) else $error("no error");
endmodule : amis_chk
bind amis_top amis_chk #(.HAS_PORT2(HAS_PORT2)) amis_chk_inst (.sys_clk(sys_clk), .rst(rst),
  .av_req(av_req), .av_rsp(av_rsp), .pins(pins), .port1_mute_in(port1_mute_in),
  .port2_mute_in(port2_mute_in));

// ---- amis_top_tb.sv ----
`timescale 1ns/1ns
module amis_top_tb;
  import amis_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  amis_av_req_t av_req = '0;
  amis_av_rsp_t av_rsp;
  amis_pins_t   pins = '0;
  logic         m1, m2;
  logic [31:0]  rd;
  logic [1:0]   rs;
  logic [3:0]   be_sel = 4'hf;
  amis_av_rsp_t av_rsp_r;
  logic         m1_r, m2_r;
  logic [31:0]  rd_r;
  logic [1:0]   rs_r;
  int           n_fail = 0, checked = 0, cyc = 0;
  amis_top amis_top_inst (.sys_clk(sys_clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
    .pins(pins), .port1_mute_in(m1), .port2_mute_in(m2));
  amis_top #(.HAS_PORT2(1'b0)) amis_top_reduced_inst (.sys_clk(sys_clk), .rst(rst),
    .av_req(av_req), .av_rsp(av_rsp_r), .pins(pins),
    .port1_mute_in(m1_r), .port2_mute_in(m2_r));
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      summarize();
    end
  end
  ////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    av_req <= '{a, ~w, w, d, be_sel};
    do @(posedge sys_clk); while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    rs = av_rsp.response;
    rd_r = av_rsp_r.readdata;
    rs_r = av_rsp_r.response;
    av_req <= '0;
    @(posedge sys_clk);
  endtask : bus
  function automatic logic mx(input logic [2:0] c, input logic [6:0] p);
    return (c == 3'h0) ? 1'b0 : p[3'h7 - c];
  endfunction : mx
  task automatic t_reset();
    bus(1'b0, PORT1_CFG_ADDR, '0);
    chk("port1 reset", 32'h0, rd);
    bus(1'b0, PORT2_CFG_ADDR, '0);
    chk("port2 reset", 32'h0, rd);
    $display("reset test done");
  endtask : t_reset
  task automatic t_codes();
    logic [6:0] p;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, PORT1_CFG_ADDR, 32'(i));
      bus(1'b1, PORT2_CFG_ADDR, 32'(7 - i));
      bus(1'b0, PORT1_CFG_ADDR, '0);
      chk("port1 sel", 32'(i), rd);
      bus(1'b0, PORT2_CFG_ADDR, '0);
      chk("port2 sel", 32'(7 - i), rd);
      chk("reduced port2 rd", 32'h0, rd_r);
      chk("reduced port2 rs", 32'(RESP_OKAY), 32'(rs_r));
      for (int k = 0; k < 2; k++) begin
        p = (i == 0) ? 7'h7f : 7'h40 >> (i - 1);
        if (k == 1) p = ~p;
        pins <= p;
        @(negedge sys_clk);
        chk("port1 mute", 32'(mx(3'(i), p)), 32'(m1));
        chk("port2 mute", 32'(mx(3'(7 - i), p)), 32'(m2));
        chk("reduced port1 mute", 32'(mx(3'(i), p)), 32'(m1_r));
        chk("reduced port2 mute", 32'h0, 32'(m2_r));
        @(posedge sys_clk);
      end
    end
    $display("code test done");
  endtask : t_codes
  task automatic t_unmapped();
    bus(1'b1, 32'h4000_0024, 32'h5);
    chk("unmapped wr resp", 32'(RESP_SLVERR), 32'(rs));
    bus(1'b0, 32'h4000_0024, '0);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
    chk("unmapped data", 32'h0, rd);
    be_sel = 4'he;
    bus(1'b1, PORT1_CFG_ADDR, 32'h3);
    be_sel = 4'hf;
    bus(1'b0, PORT1_CFG_ADDR, '0);
    chk("port1 kept", 32'h7, rd);
    $display("unmapped test done");
  endtask : t_unmapped
  task automatic t_rereset();
    bus(1'b1, PORT2_CFG_ADDR, 32'h6);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, PORT1_CFG_ADDR, '0);
    chk("port1 rereset", 32'h0, rd);
    bus(1'b0, PORT2_CFG_ADDR, '0);
    chk("port2 rereset", 32'h0, rd);
    chk("port1 mute rereset", 32'h0, 32'(m1));
    $display("rereset test done");
  endtask : t_rereset
  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_codes();
    t_unmapped();
    t_rereset();
    summarize();
  end
endmodule : amis_top_tb
